// ==== tpmt_engine.sv ====
// timer-plus-pattern transfer engine with interrupt acceptance
// assumes table memory answers a read in the next cycle; match and cpu inputs share the clock
`timescale 1ns/1ps
`include "tpmt_map.svh"

// Operation
// - auto add mode writes compare plus fetched delta back into compare register
// - ring mode replays one stored pattern cyclically from its first entry
// - transfer countdown drops by one per completed transfer
// - in every mode countdown reaching zero raises a cpu interrupt request
// - transfer requests are served during the nmi handler; masks, protected pairs and self-looping branches stop them
// - enable allows high priority requests; enable plus priority flag allows low too
// - return from interrupt clears the nmi in-service flag
// - nmi held only while in service, inside a protected instruction pair or in a self-looping bit branch
// - self-looping bit branch holds every interrupt and transfer pending
// - table pointers increment in low byte only, carry discarded
// - with external memory, timer pointer low byte at hot range causes spurious write
// - spurious write goes to compare register address with pointer location low byte
// - spurious write is a normal external write with programmed wait states
// - one match request loads compare register and selected pattern buffer half
// - mode bit chooses timer pointer retained or incremented
// - ring step counter tracks position, ring length gives pattern length
module tpmt_engine
	import tpmt_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [4:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic MATCH_A,
	input wire logic MATCH_B,
	input wire logic NMI_N,
	input wire logic RETURN_FROM_INTERRUPT_INSTR,
	input wire logic PROTECTED_PAIR,
	input wire logic BRANCH_IF_BIT_CLEAR_LOOP,
	output logic [15:0] MEM_ADDR,
	output logic MEM_RD,
	input wire logic [7:0] MEM_RDATA,
	output logic [7:0] COMPARE_REG_A,
	output logic [7:0] COMPARE_REG_B,
	output logic [7:0] PATTERN_BUFFER_LOW,
	output logic [7:0] PATTERN_BUFFER_HIGH,
	output logic NMI_TAKE,
	output logic INT_TAKE_A,
	output logic INT_TAKE_B,
	output logic INT_PEND,
	input wire logic EXT_WAIT,
	output logic EXT_WR_N,
	output logic [15:0] EXT_ADDR,
	output logic [7:0] EXT_DATA
);
	tpmt_eng_st_t q, d;
	tpmt_ctl_if c ();

	// low-byte increment, carry out of bit 7 dropped
	function automatic logic [15:0] inc_low(input logic [15:0] p);
		inc_low = {p[15:8], p[7:0] + 8'h01};
	endfunction : inc_low

	logic sel, nmi_edge, spur, ring;
	logic [1:0] live, hi_v, lo_v, take;
	logic [7:0] tloc, nstep, ncnt;
	logic [15:0] tloc_addr;

	assign sel = q.mode[`TPMT_M_CHB];
	assign ring = q.mode[`TPMT_M_RING];
	assign live = q.flg & ~q.mask;
	assign hi_v = live & q.prio;
	assign lo_v = live & ~q.prio;
	assign tloc = q.chp + `TPMT_TTPL_OFS;
	assign tloc_addr = {`TPMT_CHAN_HI, tloc};
	assign spur = q.memx[`TPMT_X_EXT] && tloc_addr >= `TPMT_HOT_LO && tloc_addr <= `TPMT_HOT_HI;
	assign nstep = q.rstep - 8'h01;
	assign ncnt = q.cnt - 8'h01;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		d.rdata = 8'h00;
		d.mrd = 1'b0;
		d.xgo = 1'b0;
		take = 2'b00;
		// nmi pin: third and second flop must agree before a change counts
		d.ns = {q.ns[1:0], NMI_N};
		nmi_edge = (q.ns[1] == q.ns[2]) && !q.ns[2] && q.nlvl;
		if (q.ns[1] == q.ns[2]) begin
			d.nlvl = q.ns[2];
		end
		if (WR) begin
			case (ADDR)
				`TPMT_R_MODE: d.mode = WDATA;
				`TPMT_R_CNT: d.cnt = WDATA;
				`TPMT_R_RSTEP: d.rstep = WDATA;
				`TPMT_R_RLEN: d.rlen = WDATA;
				`TPMT_R_TTPL: d.ttp[7:0] = WDATA;
				`TPMT_R_TTPH: d.ttp[15:8] = WDATA;
				`TPMT_R_PTPL: begin
					d.ptp[7:0] = WDATA;
					d.pbase = WDATA;
				end
				`TPMT_R_PTPH: d.ptp[15:8] = WDATA;
				`TPMT_R_CRA: d.cra = WDATA;
				`TPMT_R_CRB: d.crb = WDATA;
				`TPMT_R_PLO: d.plo = WDATA;
				`TPMT_R_PHI: d.phi = WDATA;
				`TPMT_R_FLAG: begin
					d.flg = q.flg & ~WDATA[1:0];
					d.nmip = q.nmip & ~WDATA[2];
				end
				`TPMT_R_MASK: d.mask = WDATA[1:0];
				`TPMT_R_PRIO: d.prio = WDATA[1:0];
				`TPMT_R_PSW: begin
					d.gie = WDATA[0];
					d.in_service_priority_flag = WDATA[1];
					d.nonmask_in_service_flag = WDATA[2];
				end
				`TPMT_R_MEMX: d.memx = WDATA;
				`TPMT_R_CHP: d.chp = WDATA;
				default: ;
			endcase
		end
		if (RD) begin
			case (ADDR)
				`TPMT_R_MODE: d.rdata = q.mode;
				`TPMT_R_CNT: d.rdata = q.cnt;
				`TPMT_R_RSTEP: d.rdata = q.rstep;
				`TPMT_R_RLEN: d.rdata = q.rlen;
				`TPMT_R_TTPL: d.rdata = q.ttp[7:0];
				`TPMT_R_TTPH: d.rdata = q.ttp[15:8];
				`TPMT_R_PTPL: d.rdata = q.ptp[7:0];
				`TPMT_R_PTPH: d.rdata = q.ptp[15:8];
				`TPMT_R_CRA: d.rdata = q.cra;
				`TPMT_R_CRB: d.rdata = q.crb;
				`TPMT_R_PLO: d.rdata = q.plo;
				`TPMT_R_PHI: d.rdata = q.phi;
				`TPMT_R_FLAG: d.rdata = {5'h00, q.nmip, q.flg};
				`TPMT_R_MASK: d.rdata = {6'h00, q.mask};
				`TPMT_R_PRIO: d.rdata = {6'h00, q.prio};
				`TPMT_R_PSW: d.rdata = {5'h00, q.nonmask_in_service_flag, q.in_service_priority_flag, q.gie};
				`TPMT_R_MEMX: d.rdata = q.memx;
				`TPMT_R_CHP: d.rdata = q.chp;
				`TPMT_R_STAT: d.rdata = {4'h0, q.st, q.xgo | c.xw_busy};
				default: d.rdata = 8'h00;
			endcase
		end
		// cpu acknowledge of a maskable request clears its flag
		if (c.hi_go) begin
			take = hi_v[0] ? 2'b01 : 2'b10;
		end else if (c.lo_go) begin
			take = lo_v[0] ? 2'b01 : 2'b10;
		end
		d.flg = d.flg & ~take;
		// nmi in service: return clears it, acceptance sets it and wins
		if (RETURN_FROM_INTERRUPT_INSTR) begin
			d.nonmask_in_service_flag = 1'b0;
		end
		if (c.nmi_go) begin
			d.nmip = 1'b0;
			d.nonmask_in_service_flag = 1'b1;
		end
		if (nmi_edge) begin
			d.nmip = 1'b1;
		end
		// a match on the channel not owned by the engine goes straight to the cpu
		if (MATCH_A) begin
			if (q.mode[`TPMT_M_EN] && !sel) begin
				d.pend[0] = 1'b1;
			end else begin
				d.flg[0] = 1'b1;
			end
		end
		if (MATCH_B) begin
			if (q.mode[`TPMT_M_EN] && sel) begin
				d.pend[1] = 1'b1;
			end else begin
				d.flg[1] = 1'b1;
			end
		end
		case (q.st)
			S_IDLE: begin
				if (q.pend[sel] && q.cnt == 8'h00) begin
					d.pend[sel] = 1'b0;
					d.flg[sel] = 1'b1;
				end else if (c.ms_go) begin
					d.pend[sel] = 1'b0;
					d.chb = sel;
					d.maddr = q.ttp;
					d.mrd = 1'b1;
					d.st = S_RDT;
				end
			end
			S_RDT: begin
				d.maddr = q.ptp;
				d.mrd = 1'b1;
				d.st = S_RDD;
			end
			S_RDD: begin
				d.tdat = MEM_RDATA;
				d.st = S_APPLY;
			end
			S_APPLY: begin
				if (q.chb) begin
					d.crb = q.mode[`TPMT_M_AUTO] ? q.crb + q.tdat : q.tdat;
				end else begin
					d.cra = q.mode[`TPMT_M_AUTO] ? q.cra + q.tdat : q.tdat;
				end
				if (q.mode[`TPMT_M_HALF]) begin
					d.phi = MEM_RDATA;
				end else begin
					d.plo = MEM_RDATA;
				end
				if (q.mode[`TPMT_M_TINC]) begin
					d.ttp = inc_low(q.ttp);
				end
				d.ptp = inc_low(q.ptp);
				if (ring) begin
					d.rstep = nstep;
					if (nstep == 8'h00) begin
						d.rstep = q.rlen;
						d.ptp[7:0] = q.pbase;
					end
				end
				d.cnt = ncnt;
				if (ncnt == 8'h00) begin
					d.flg[q.chb] = 1'b1;
				end
				if (spur) begin
					d.xgo = 1'b1;
					d.st = S_SPUR;
				end else begin
					d.st = S_IDLE;
				end
			end
			S_SPUR: begin
				if (!q.xgo && !c.xw_busy) begin
					d.st = S_IDLE;
				end
			end
			default: d.st = S_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			q <= '0;
			q.memx <= `TPMT_MEMX_RST;
			q.chp <= `TPMT_CHP_RST;
			q.mask <= 2'b11;
			q.ns <= 3'h7;
			q.nlvl <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------------------------
	// helpers and outputs
	// ---------------------------------------------------------------
	assign c.ms_req = (q.st == S_IDLE) && q.pend[sel] && !q.mask[sel] && q.cnt != 8'h00;
	assign c.hi_req = |hi_v;
	assign c.lo_req = |lo_v;
	assign c.nmi_req = q.nmip;
	assign c.gie = q.gie;
	assign c.in_service_priority_flag = q.in_service_priority_flag;
	assign c.nonmask_in_service_flag = q.nonmask_in_service_flag;
	assign c.prot_win = PROTECTED_PAIR;
	assign c.bf_hold = BRANCH_IF_BIT_CLEAR_LOOP;
	assign c.xw_go = q.xgo;
	assign c.xw_addr = q.chb ? `TPMT_SFR_CRB : `TPMT_SFR_CRA;
	assign c.xw_data = tloc;
	assign c.xw_waits = {q.memx[`TPMT_X_PW1], q.memx[`TPMT_X_PW0]};

	tpmt_accept u_acc (
		.clk(SYS_CLK),
		.rst(RST),
		.c(c.acc)
	);

	tpmt_xwrite u_xw (
		.clk(SYS_CLK),
		.rst(RST),
		.c(c.xw),
		.wait_pin(EXT_WAIT),
		.ext_wr_n(EXT_WR_N),
		.ext_addr(EXT_ADDR),
		.ext_data(EXT_DATA)
	);

	assign RDATA = q.rdata;
	assign MEM_ADDR = q.maddr;
	assign MEM_RD = q.mrd;
	assign COMPARE_REG_A = q.cra;
	assign COMPARE_REG_B = q.crb;
	assign PATTERN_BUFFER_LOW = q.plo;
	assign PATTERN_BUFFER_HIGH = q.phi;
	assign NMI_TAKE = c.nmi_go;
	assign INT_TAKE_A = take[0];
	assign INT_TAKE_B = take[1];
	assign INT_PEND = |live;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic [7:0] sum_a;
	assign sum_a = (q.chb ? q.crb : q.cra) + q.tdat;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	auto_add_a: assert property ((q.st == S_APPLY && q.mode[`TPMT_M_AUTO]) |=> (q.chb ? q.crb : q.cra) == $past(sum_a))
		else $error("compare sum not written");
	count_down_a: assert property ((q.st == S_APPLY) |=> q.cnt == 8'($past(q.cnt) - 8'h01))
		else $error("countdown not decremented");
	zero_irq_a: assert property ((q.st == S_APPLY && q.cnt == 8'h01) |=> q.flg[q.chb])
		else $error("no interrupt at zero count");
	ring_rewind_a: assert property ((q.st == S_APPLY && ring && q.rstep == 8'h01)
		|=> (q.rstep == q.rlen && q.ptp[7:0] == q.pbase)) else $error("ring not rewound");
	ptr_high_a: assert property ((q.st == S_APPLY) |=> (q.ttp[15:8] == $past(q.ttp[15:8])
		&& q.ptp[15:8] == $past(q.ptp[15:8]))) else $error("pointer high byte changed");
	return_from_interrupt_instr_clear_a: assert property ((RETURN_FROM_INTERRUPT_INSTR && !c.nmi_go) |=> !q.nonmask_in_service_flag)
		else $error("nmi in service not cleared");
	spur_write_a: assert property ((q.st == S_APPLY && spur) |=> (c.xw_go && c.xw_data == tloc) ##1 c.xw_busy)
		else $error("spurious write missing");
	zero_pass_a: assert property ((q.st == S_IDLE && q.pend[sel] && q.cnt == 8'h00) |=> (q.flg[sel] && q.st == S_IDLE))
		else $error("zero-count request not passed on");
	ring_cover: cover property (q.st == S_APPLY && ring && q.rstep == 8'h01);
	spur_cover: cover property (q.st == S_SPUR ##1 q.st == S_IDLE);
	nmi_cover: cover property (c.nmi_go ##[1:20] c.ms_go);
	auto_cover: cover property (q.st == S_APPLY && q.mode[`TPMT_M_AUTO]);
	zero_cover: cover property (q.st == S_IDLE && q.pend[sel] && q.cnt == 8'h00);
endmodule : tpmt_engine

// ==== tpmt_map.svh ====
// register offsets, field positions, reset values and fixed addresses
// assumes an 8-bit register port with a 5-bit address
`ifndef TPMT_MAP_SVH
`define TPMT_MAP_SVH
`define TPMT_R_MODE 5'h00
`define TPMT_R_CNT 5'h01
`define TPMT_R_RSTEP 5'h02
`define TPMT_R_RLEN 5'h03
`define TPMT_R_TTPL 5'h04
`define TPMT_R_TTPH 5'h05
`define TPMT_R_PTPL 5'h06
`define TPMT_R_PTPH 5'h07
`define TPMT_R_CRA 5'h08
`define TPMT_R_CRB 5'h09
`define TPMT_R_PLO 5'h0A
`define TPMT_R_PHI 5'h0B
`define TPMT_R_FLAG 5'h0C
`define TPMT_R_MASK 5'h0D
`define TPMT_R_PRIO 5'h0E
`define TPMT_R_PSW 5'h0F
`define TPMT_R_MEMX 5'h10
`define TPMT_R_CHP 5'h11
`define TPMT_R_STAT 5'h12
`define TPMT_M_CHB 0
`define TPMT_M_HALF 1
`define TPMT_M_AUTO 2
`define TPMT_M_RING 3
`define TPMT_M_TINC 4
`define TPMT_M_EN 5
`define TPMT_X_EXT 0
`define TPMT_X_PW0 4
`define TPMT_X_PW1 5
`define TPMT_MEMX_RST 8'h20
`define TPMT_CHP_RST 8'hCF
`define TPMT_WAIT_PIN 2'h3
`define TPMT_CHAN_HI 8'hFE
`define TPMT_TTPL_OFS 8'h04
`define TPMT_HOT_LO 16'hFED0
`define TPMT_HOT_HI 16'hFEDF
`define TPMT_SFR_CRA 16'hFF10
`define TPMT_SFR_CRB 16'hFF11
`endif

// ==== tpmt_pkg.sv ====
// types shared by the transfer engine and its helpers
// assumes tpmt_map.svh for all numeric constants
package tpmt_pkg;
	typedef enum logic [2:0] {S_IDLE, S_RDT, S_RDD, S_APPLY, S_SPUR} tpmt_state_t;
	typedef struct packed {
		logic busy;
		logic ext;
		logic [1:0] cnt;
		logic [2:0] ws;
		logic wl;
		logic [15:0] addr;
		logic [7:0] data;
	} tpmt_xw_st_t;
	typedef struct packed {
		tpmt_state_t st;
		logic [7:0] mode, cnt, rstep, rlen, pbase, cra, crb, plo, phi, tdat, memx, chp, rdata;
		logic [15:0] ttp, ptp, maddr;
		logic [1:0] flg, pend, mask, prio;
		logic nmip, gie, in_service_priority_flag, nonmask_in_service_flag, chb, mrd, xgo, nlvl;
		logic [2:0] ns;
	} tpmt_eng_st_t;
endpackage : tpmt_pkg

// ==== tpmt_ctl_if.sv ====
// carrier between the engine, the acceptance logic and the external write unit
// assumes all three sit on the same clock
`timescale 1ns/1ps
interface tpmt_ctl_if;
	logic xw_go, xw_busy;
	logic [15:0] xw_addr;
	logic [7:0] xw_data;
	logic [1:0] xw_waits;
	logic ms_req, hi_req, lo_req, nmi_req, gie, in_service_priority_flag, nonmask_in_service_flag, prot_win, bf_hold;
	logic ms_go, nmi_go, hi_go, lo_go;
	modport eng (output xw_go, xw_addr, xw_data, xw_waits, ms_req, hi_req, lo_req, nmi_req, gie, in_service_priority_flag, nonmask_in_service_flag,
		prot_win, bf_hold, input xw_busy, ms_go, nmi_go, hi_go, lo_go);
	modport xw (input xw_go, xw_addr, xw_data, xw_waits, output xw_busy);
	modport acc (input ms_req, hi_req, lo_req, nmi_req, gie, in_service_priority_flag, nonmask_in_service_flag, prot_win, bf_hold,
		output ms_go, nmi_go, hi_go, lo_go);
endinterface : tpmt_ctl_if

// ==== tpmt_accept.sv ====
// request acceptance: non-maskable, transfer service, high and low priority
// assumes requests and flags come from logic on the same clock
`timescale 1ns/1ps
module tpmt_accept
	import tpmt_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	tpmt_ctl_if.acc c
);
	logic hold;
	assign hold = c.bf_hold | c.prot_win;
	assign c.nmi_go = c.nmi_req & ~c.nonmask_in_service_flag & ~c.prot_win & ~c.bf_hold;
	assign c.ms_go = c.ms_req & ~hold & ~c.nmi_go;
	assign c.hi_go = c.hi_req & c.gie & ~hold & ~c.nmi_go & ~c.ms_req;
	assign c.lo_go = c.lo_req & c.gie & c.in_service_priority_flag & ~hold & ~c.nmi_go & ~c.ms_req & ~c.hi_req;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	nmi_block_a: assert property ((c.nonmask_in_service_flag || c.prot_win) |-> !c.nmi_go) else $error("nmi taken while held");
	loop_hold_a: assert property (c.bf_hold |-> !(c.nmi_go || c.ms_go || c.hi_go || c.lo_go))
		else $error("request taken during self loop");
	ms_in_nmi_a: assert property ((c.ms_req && c.nonmask_in_service_flag && !hold) |-> c.ms_go)
		else $error("transfer refused in nmi handler");
	low_gate_a: assert property (c.lo_go |-> (c.gie && c.in_service_priority_flag)) else $error("low request taken without enables");
endmodule : tpmt_accept

// ==== tpmt_xwrite.sv ====
// external write cycle with programmable wait states
// assumes the wait pin is asynchronous to the clock
`timescale 1ns/1ps
`include "tpmt_map.svh"
module tpmt_xwrite
	import tpmt_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	tpmt_ctl_if.xw c,
	input wire logic wait_pin,
	output logic ext_wr_n,
	output logic [15:0] ext_addr,
	output logic [7:0] ext_data
);
	tpmt_xw_st_t q, d;

	always_comb begin
		d = q;
		d.ws = {q.ws[1:0], wait_pin};
		if (q.ws[1] == q.ws[2]) begin
			d.wl = q.ws[2];
		end
		if (!q.busy) begin
			if (c.xw_go) begin
				d.busy = 1'b1;
				d.ext = (c.xw_waits == `TPMT_WAIT_PIN);
				d.cnt = (c.xw_waits == `TPMT_WAIT_PIN) ? 2'h0 : c.xw_waits;
				d.addr = c.xw_addr;
				d.data = c.xw_data;
			end
		end else if (q.cnt != 2'h0) begin
			d.cnt = q.cnt - 2'h1;
		end else if (!(q.ext && q.wl)) begin
			d.busy = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign c.xw_busy = q.busy;
	assign ext_wr_n = ~q.busy;
	assign ext_addr = q.addr;
	assign ext_data = q.data;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	zero_wait_a: assert property ((c.xw_go && !q.busy && c.xw_waits == 2'h0) |=> q.busy ##1 !q.busy)
		else $error("zero-wait write not one cycle");
	two_wait_a: assert property ((c.xw_go && !q.busy && c.xw_waits == 2'h2) |=> q.busy[*3] ##1 !q.busy)
		else $error("two-wait write not three cycles");
endmodule : tpmt_xwrite

// ==== tpmt_mem_model.sv ====
// table memory and external wait partner of the transfer engine
// assumes one clock; table data stand only in the cycle after a table read
`timescale 1ns/1ps
module tpmt_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata,
	input wire logic ext_wr_n,
	output logic ext_wait
);
	logic [7:0] mem [0:65535];
	int stall = 0;
	int low_n;
	// outside a read the data lines show junk, never the last value
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_rdata <= 8'hA5;
			low_n <= 0;
			ext_wait <= 1'b0;
		end else begin
			mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
			low_n <= ext_wr_n ? 0 : low_n + 1;
			ext_wait <= !ext_wr_n && (low_n < stall);
		end
	end
endmodule : tpmt_mem_model

// ==== timed_pattern_macro_transfer_test.sv ====
// self-checking bench for the timed pattern transfer engine
// assumes the table memory model answers one cycle after each table read
`timescale 1ns/1ps
`include "tpmt_map.svh"
module timed_pattern_macro_transfer_test
	import tpmt_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, ma = 1'b0, mb = 1'b0, nmi_n = 1'b1;
	logic rfi = 1'b0, prot = 1'b0, bfl = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00, rdata, mem_rdata, cra, crb, plo, phi, ext_data, x_data, v, e;
	logic [15:0] mem_addr, ext_addr, x_addr, tp, pp;
	logic mem_rd, nmi_take, take_a, take_b, int_pend, ext_wait, ext_wr_n;
	int n_mismatch = 0, checks_done = 0, n_nmi = 0, n_ta = 0, n_tb = 0, low_cyc = 0, l0;

	always #20 clk = ~clk;

	tpmt_engine u_tpmt_engine (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .MATCH_A(ma), .MATCH_B(mb), .NMI_N(nmi_n), .RETURN_FROM_INTERRUPT_INSTR(rfi),
		.PROTECTED_PAIR(prot), .BRANCH_IF_BIT_CLEAR_LOOP(bfl), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
		.MEM_RDATA(mem_rdata), .COMPARE_REG_A(cra), .COMPARE_REG_B(crb), .PATTERN_BUFFER_LOW(plo),
		.PATTERN_BUFFER_HIGH(phi), .NMI_TAKE(nmi_take), .INT_TAKE_A(take_a), .INT_TAKE_B(take_b),
		.INT_PEND(int_pend), .EXT_WAIT(ext_wait), .EXT_WR_N(ext_wr_n), .EXT_ADDR(ext_addr), .EXT_DATA(ext_data));

	tpmt_mem_model u_tpmt_mem_model (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_rdata(mem_rdata), .ext_wr_n(ext_wr_n), .ext_wait(ext_wait));

	// --------------------------------
	// monitors of accepted requests and external writes
	// --------------------------------
	always @(posedge clk) begin
		n_nmi <= n_nmi + int'(nmi_take);
		n_ta <= n_ta + int'(take_a);
		n_tb <= n_tb + int'(take_b);
		low_cyc <= ext_wr_n ? low_cyc : low_cyc + 1;
		if (!ext_wr_n) begin
			x_addr <= ext_addr;
			x_data <= ext_data;
		end
	end

	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [15:0] inc_lo(input logic [15:0] p);
		return {p[15:8], p[7:0] + 8'h01};
	endfunction : inc_lo

	function automatic logic [15:0] hot_loc(input logic [7:0] chp);
		return 16'hFE00 + {8'h00, chp} + 16'h0004;
	endfunction : hot_loc

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [4:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk({8'h00, rdata}, {8'h00, x});
	endtask : rchk

	task automatic setp(input logic [15:0] t, input logic [15:0] p);
		wr(`TPMT_R_TTPL, t[7:0]);
		wr(`TPMT_R_TTPH, t[15:8]);
		wr(`TPMT_R_PTPL, p[7:0]);
		wr(`TPMT_R_PTPH, p[15:8]);
	endtask : setp

	task automatic fire(input logic b);
		@(posedge clk);
		ma <= !b;
		mb <= b;
		@(posedge clk);
		ma <= 1'b0;
		mb <= 1'b0;
		cyc(8);
	endtask : fire

	task automatic nmi_edge;
		@(posedge clk);
		nmi_n <= 1'b0;
		cyc(5);
		nmi_n <= 1'b1;
		cyc(5);
	endtask : nmi_edge

	task automatic wnmi(input int target);
		for (int i = 0; i < 12 && n_nmi < target; i++)
			@(posedge clk);
		chk(16'(n_nmi), 16'(target));
		if (n_nmi < target)
			final_report();
	endtask : wnmi

	task automatic rfi_pulse;
		@(posedge clk);
		rfi <= 1'b1;
		@(posedge clk);
		rfi <= 1'b0;
		cyc(1);
	endtask : rfi_pulse

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		void'($urandom(32'hda29c7c7));
		for (int i = 0; i < 65536; i++)
			u_tpmt_mem_model.mem[i] = 8'($urandom);
		cyc(6);
		rst <= 1'b0;
		rchk(`TPMT_R_MEMX, 8'h20);
		rchk(`TPMT_R_CHP, 8'hCF);
		rchk(5'h1F, 8'h00);
		$display("test reset values done");
		// mode: enable, timer pointer increment, channel A, low half
		wr(`TPMT_R_MASK, 8'h00);
		wr(`TPMT_R_MODE, 8'h30);
		wr(`TPMT_R_CNT, 8'h04);
		tp = 16'hB1FE;
		pp = 16'hB0FF;
		setp(tp, pp);
		for (int k = 0; k < 4; k++) begin
			fire(1'b0);
			chk({8'h00, cra}, {8'h00, u_tpmt_mem_model.mem[tp]});
			chk({8'h00, plo}, {8'h00, u_tpmt_mem_model.mem[pp]});
			tp = inc_lo(tp);
			pp = inc_lo(pp);
		end
		rchk(`TPMT_R_TTPL, tp[7:0]);
		rchk(`TPMT_R_TTPH, 8'hB1);
		rchk(`TPMT_R_PTPH, 8'hB0);
		rchk(`TPMT_R_CNT, 8'h00);
		chk(16'(low_cyc), 16'h0000);
		wr(`TPMT_R_FLAG, 8'h07);
		v = cra;
		fire(1'b0);
		chk({8'h00, cra}, {8'h00, v});
		chk({15'h0000, int_pend}, 16'h0001);
		$display("test counted transfers done");
		// mode: enable, auto add, high half, channel B, pointer retained
		wr(`TPMT_R_FLAG, 8'h07);
		wr(`TPMT_R_MODE, 8'h27);
		e = 8'($urandom);
		wr(`TPMT_R_CRB, e);
		wr(`TPMT_R_CNT, 8'h03);
		tp = 16'hB200;
		pp = 16'hB300;
		setp(tp, pp);
		for (int k = 0; k < 3; k++) begin
			fire(1'b1);
			e = e + u_tpmt_mem_model.mem[tp];
			chk({8'h00, crb}, {8'h00, e});
			chk({8'h00, phi}, {8'h00, u_tpmt_mem_model.mem[pp]});
			pp = inc_lo(pp);
		end
		rchk(`TPMT_R_TTPL, 8'h00);
		$display("test auto add done");
		// mode: enable, ring, channel A, low half
		wr(`TPMT_R_FLAG, 8'h07);
		wr(`TPMT_R_MODE, 8'h28);
		wr(`TPMT_R_RLEN, 8'h03);
		wr(`TPMT_R_RSTEP, 8'h03);
		wr(`TPMT_R_CNT, 8'h07);
		setp(16'hB400, 16'hB410);
		for (int k = 0; k < 7; k++) begin
			fire(1'b0);
			chk({8'h00, plo}, {8'h00, u_tpmt_mem_model.mem[16'hB410 + 16'(k % 3)]});
		end
		chk({15'h0000, int_pend}, 16'h0001);
		rchk(`TPMT_R_FLAG, 8'h01);
		$display("test ring done");
		wr(`TPMT_R_FLAG, 8'h07);
		wr(`TPMT_R_MODE, 8'h30);
		wr(`TPMT_R_CNT, 8'h01);
		setp(16'hB500, 16'hB600);
		v = cra;
		@(posedge clk);
		bfl <= 1'b1;
		fire(1'b0);
		chk({8'h00, cra}, {8'h00, v});
		bfl <= 1'b0;
		cyc(8);
		chk({8'h00, cra}, {8'h00, u_tpmt_mem_model.mem[16'hB500]});
		$display("test branch hold done");
		u_tpmt_mem_model.stall = 5;
		for (int w = 0; w < 3; w++) begin
			wr(`TPMT_R_FLAG, 8'h07);
			wr(`TPMT_R_MODE, 8'h30 | 8'(w & 1));
			wr(`TPMT_R_CNT, 8'h01);
			wr(`TPMT_R_MEMX, {2'b00, 2'(w), 4'h1});
			l0 = low_cyc;
			fire(1'(w));
			cyc(6);
			chk(16'(low_cyc - l0), 16'(w + 1));
			chk(x_addr, (w & 1) ? `TPMT_SFR_CRB : `TPMT_SFR_CRA);
			chk({8'h00, x_data}, {8'h00, 8'(hot_loc(8'hCF))});
		end
		wr(`TPMT_R_CHP, 8'h00);
		wr(`TPMT_R_CNT, 8'h01);
		l0 = low_cyc;
		fire(1'b0);
		cyc(6);
		chk(16'(low_cyc - l0), 16'h0000);
		wr(`TPMT_R_MEMX, 8'h20);
		$display("test spurious write done");
		// transfers off so that matches only raise flags
		wr(`TPMT_R_MODE, 8'h00);
		wr(`TPMT_R_PRIO, 8'h01);
		wr(`TPMT_R_PSW, 8'h00);
		wr(`TPMT_R_FLAG, 8'h07);
		l0 = n_ta;
		fire(1'b0);
		chk(16'(n_ta), 16'(l0));
		wr(`TPMT_R_PSW, 8'h01);
		cyc(2);
		chk(16'(n_ta), 16'(l0 + 1));
		wr(`TPMT_R_PSW, 8'h01);
		l0 = n_tb;
		fire(1'b1);
		chk(16'(n_tb), 16'(l0));
		wr(`TPMT_R_PSW, 8'h03);
		cyc(2);
		chk(16'(n_tb), 16'(l0 + 1));
		$display("test maskable acceptance done");
		wr(`TPMT_R_PSW, 8'h00);
		wr(`TPMT_R_FLAG, 8'h07);
		l0 = n_nmi;
		nmi_edge();
		wnmi(l0 + 1);
		rchk(`TPMT_R_PSW, 8'h04);
		nmi_edge();
		chk(16'(n_nmi), 16'(l0 + 1));
		wr(`TPMT_R_MODE, 8'h30);
		wr(`TPMT_R_CNT, 8'h01);
		setp(16'hB700, 16'hB800);
		fire(1'b0);
		chk({8'h00, cra}, {8'h00, u_tpmt_mem_model.mem[16'hB700]});
		wr(`TPMT_R_FLAG, 8'h07);
		rfi_pulse();
		rchk(`TPMT_R_PSW, 8'h00);
		nmi_edge();
		wnmi(l0 + 2);
		rfi_pulse();
		prot <= 1'b1;
		nmi_edge();
		chk(16'(n_nmi), 16'(l0 + 2));
		prot <= 1'b0;
		wnmi(l0 + 3);
		$display("test nonmaskable acceptance done");
		final_report();
	end
endmodule : timed_pattern_macro_transfer_test
